/* File: core/chan_queue_fifo.sv */
/*
 * Small FIFO of channel numbers, oldest entry shown at the head.
 * Assumes the caller never pops when empty and never pushes when full.
 */
`timescale 1ns/1ps
`include "tone_irq_regs.svh"
module chan_queue_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = `QUEUE_DEPTH
) (
    input  wire logic                       clk,
    input  wire logic                       nrst,
    input  wire logic                       push,
    input  wire logic [WIDTH-1:0]           push_data,
    input  wire logic                       pop,
    output logic                            full,
    output logic                            empty,
    output logic [WIDTH-1:0]                head
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [CW-1:0]    count_q;
    wire              do_push = push && !full;
    wire              do_pop  = pop && !empty;
    wire [PW-1:0]     last    = PW'(DEPTH - 1);

    assign full  = (count_q == CW'(DEPTH));
    assign empty = (count_q == '0);
    assign head  = mem_q[rd_ptr_q];

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_q[wr_ptr_q] <= push_data;
        end
    end

    // each pop retires the oldest entry
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_q <= (wr_ptr_q == last) ? '0 : wr_ptr_q + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_q <= (rd_ptr_q == last) ? '0 : rd_ptr_q + 1'b1;
            end
            count_q <= count_q + CW'(do_push) - CW'(do_pop);
        end
    end

    property p_pop_shrinks;
        @(posedge clk) disable iff (!nrst)
        (do_pop && !do_push) |=> (count_q == $past(count_q) - 1'b1);
    endproperty
    a_pop_shrinks: assert property (p_pop_shrinks)
        else $error("queue did not shrink on read");
endmodule

/* File: core/tone_change_detect.sv */
/*
 * Catches tone disable state changes per channel and, in self-test
 * mode, changes of the per-group tone control bits; keeps a sticky
 * pending bit per channel and offers the lowest one to the queue.
 * Assumes group g owns channel 2g (side a) and 2g+1 (side b).
 */
`timescale 1ns/1ps
`include "tone_irq_regs.svh"
module tone_change_detect #(
    parameter int CHANNELS = `NUM_CHANNELS,
    parameter int GROUPS   = `NUM_GROUPS
) (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   test_en,
    input  wire logic [CHANNELS-1:0]    tone_disable,
    input  wire logic [GROUPS-1:0]      group_tone_ctrl_a,
    input  wire logic [GROUPS-1:0]      group_tone_ctrl_b,
    input  wire logic                   take,
    output logic                        evt_valid,
    output tone_irq_pkg::chan_t         evt_chan
);
    logic [CHANNELS-1:0] tone_q;
    logic [GROUPS-1:0]   ctrl_a_q;
    logic [GROUPS-1:0]   ctrl_b_q;
    logic [CHANNELS-1:0] pend_q;
    logic [CHANNELS-1:0] ctrl_evt;
    logic [CHANNELS-1:0] grant;
    wire  [CHANNELS-1:0] tone_evt = tone_disable ^ tone_q;
    wire  [CHANNELS-1:0] new_evt  = tone_evt | (test_en ? ctrl_evt : '0);

    function automatic tone_irq_pkg::chan_t lowest(input logic [CHANNELS-1:0] v);
        tone_irq_pkg::chan_t idx;
        idx = '0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = tone_irq_pkg::chan_t'(i);
            end
        end
        return idx;
    endfunction

    // side a control edges map to channel 2g, side b edges to channel 2g+1
    for (genvar g = 0; g < GROUPS; g++) begin : g_map
        assign ctrl_evt[2*g]   = group_tone_ctrl_a[g] ^ ctrl_a_q[g];
        assign ctrl_evt[2*g+1] = group_tone_ctrl_b[g] ^ ctrl_b_q[g];
    end

    assign evt_valid = |pend_q;
    assign evt_chan  = lowest(pend_q);
    assign grant     = (take && evt_valid) ? (CHANNELS'(1) << evt_chan) : '0;

    // set wins over grant so a change in the hand-off cycle is kept
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tone_q   <= '0;
            ctrl_a_q <= '0;
            ctrl_b_q <= '0;
            pend_q   <= '0;
        end else begin
            tone_q   <= tone_disable;
            ctrl_a_q <= group_tone_ctrl_a;
            ctrl_b_q <= group_tone_ctrl_b;
            pend_q   <= (pend_q & ~grant) | new_evt;
        end
    end

    property p_tone_edge_pends;
        @(posedge clk) disable iff (!nrst)
        (tone_evt != '0) |=> ((pend_q & $past(tone_evt)) == $past(tone_evt));
    endproperty
    a_tone_edge_pends: assert property (p_tone_edge_pends)
        else $error("tone change not marked pending");

    property p_test_ctrl_pends;
        @(posedge clk) disable iff (!nrst)
        (test_en && ctrl_evt != '0) |=> ((pend_q & $past(ctrl_evt)) == $past(ctrl_evt));
    endproperty
    a_test_ctrl_pends: assert property (p_test_ctrl_pends)
        else $error("test mode control change not marked pending");

    property p_normal_only_real;
        @(posedge clk) disable iff (!nrst)
        (!test_en && tone_evt == '0) |=> ((pend_q & ~$past(pend_q)) == '0);
    endproperty
    a_normal_only_real: assert property (p_normal_only_real)
        else $error("event raised without a tone change");
endmodule

/* File: core/tone_event_interrupt_fifo.sv */
/*
 * Tone event interrupt block: queues the numbers of channels whose
 * tone disable state changed, presents them in the read-only queue
 * register, holds the self-test control, and drives one level irq
 * from sticky status bits under a mask.
 * Assumes a host that issues one-cycle read or write strobes, never
 * both at once, and takes read data in the cycle after the strobe.
 */
`timescale 1ns/1ps
`include "tone_irq_regs.svh"
module tone_event_interrupt_fifo #(
    parameter int CHANNELS = `NUM_CHANNELS,
    parameter int GROUPS   = `NUM_GROUPS,
    parameter int DEPTH    = `QUEUE_DEPTH
) (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic [`ADDR_W-1:0]     addr,
    input  wire logic [7:0]             wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic [7:0]                  rdata,
    input  wire logic [CHANNELS-1:0]    tone_disable,
    input  wire logic [GROUPS-1:0]      group_tone_ctrl_a,
    input  wire logic [GROUPS-1:0]      group_tone_ctrl_b,
    output logic                        test_mode,
    output logic                        irq_pending,
    output logic                        irq
);
    localparam logic [`STAT_W-1:0] MASK_RESET = `IRQ_MASK_RESET;

    tone_irq_pkg::reg_sel_t sel;
    tone_irq_pkg::chan_t    evt_chan;
    tone_irq_pkg::chan_t    q_head;
    tone_irq_pkg::byte_t    queue_word;
    tone_irq_pkg::byte_t    rd_word;

    logic                   test_q;
    logic [`STAT_W-1:0]     status_q;
    logic [`STAT_W-1:0]     status_d;
    logic [`STAT_W-1:0]     mask_q;
    logic [7:0]             rdata_q;
    logic                   evt_valid;
    logic                   q_full;
    logic                   q_empty;
    logic                   q_push;
    logic                   q_pop;
    logic                   ovfl_evt;
    logic [`STAT_W-1:0]     set_bits;
    logic [`STAT_W-1:0]     clr_bits;

    // address decode
    assign sel = (addr == `ADDR_QUEUE)      ? tone_irq_pkg::SEL_QUEUE    :
                 (addr == `ADDR_SELFTEST)   ? tone_irq_pkg::SEL_SELFTEST :
                 (addr == `ADDR_IRQ_STATUS) ? tone_irq_pkg::SEL_STATUS   :
                 (addr == `ADDR_IRQ_MASK)   ? tone_irq_pkg::SEL_MASK     :
                                              tone_irq_pkg::SEL_NONE;

    wire wr_selftest = wr && (sel == tone_irq_pkg::SEL_SELFTEST);
    wire wr_status   = wr && (sel == tone_irq_pkg::SEL_STATUS);
    wire wr_mask     = wr && (sel == tone_irq_pkg::SEL_MASK);
    wire rd_queue    = rd && (sel == tone_irq_pkg::SEL_QUEUE);

    // change detection and per-channel pending bits
    tone_change_detect #(
        .CHANNELS (CHANNELS),
        .GROUPS   (GROUPS)
    ) u_detect (
        .clk               (clk),
        .nrst              (nrst),
        .test_en           (test_q),
        .tone_disable      (tone_disable),
        .group_tone_ctrl_a (group_tone_ctrl_a),
        .group_tone_ctrl_b (group_tone_ctrl_b),
        .take              (q_push),
        .evt_valid         (evt_valid),
        .evt_chan          (evt_chan)
    );

    // a full queue holds events back in the pending bits instead of
    // losing them; overflow only flags that back-pressure happened
    assign q_push   = evt_valid && !q_full;
    assign ovfl_evt = evt_valid && q_full;

    // a read of the queue retires the oldest entry
    assign q_pop = rd_queue && !q_empty;

    chan_queue_fifo #(
        .WIDTH (5),
        .DEPTH (DEPTH)
    ) u_queue (
        .clk       (clk),
        .nrst      (nrst),
        .push      (q_push),
        .push_data (evt_chan),
        .pop       (q_pop),
        .full      (q_full),
        .empty     (q_empty),
        .head      (q_head)
    );

    // queue word: pending flag, two zero bits, channel number
    // an empty queue reads all zero, never a stale head
    assign queue_word = q_empty ? 8'h00 : {1'b1, 2'b00, q_head};

    assign rd_word = (sel == tone_irq_pkg::SEL_QUEUE)    ? queue_word               :
                     (sel == tone_irq_pkg::SEL_SELFTEST) ? {7'h00, test_q}          :
                     (sel == tone_irq_pkg::SEL_STATUS)   ? {6'h00, status_q}        :
                     (sel == tone_irq_pkg::SEL_MASK)     ? {6'h00, mask_q}          :
                                                           8'h00;

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= `QUEUE_RESET;
        end else begin
            rdata_q <= rd ? rd_word : 8'h00;
        end
    end
    assign rdata = rdata_q;

    // self-test control; reserved bits are not stored and read zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            test_q <= 1'(`SELFTEST_RESET);
        end else if (wr_selftest) begin
            test_q <= wdata[`SELFTEST_EN_BIT];
        end
    end
    assign test_mode = test_q;

    // sticky status, write one to clear; a set in the clear cycle wins
    assign set_bits = {ovfl_evt, q_push};
    assign clr_bits = wr_status ? wdata[`STAT_W-1:0] : '0;
    assign status_d = (status_q & ~clr_bits) | set_bits;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status_q <= '0;
            mask_q   <= MASK_RESET;
        end else begin
            status_q <= status_d;
            if (wr_mask) begin
                mask_q <= wdata[`STAT_W-1:0];
            end
        end
    end

    assign irq         = |(status_q & mask_q);
    assign irq_pending = !q_empty;

    // checks

    property p_pending_bit;
        @(posedge clk) disable iff (!nrst)
        rd_queue |=> (rdata[`QUEUE_PEND_BIT] == !$past(q_empty));
    endproperty
    a_pending_bit: assert property (p_pending_bit)
        else $error("queue pending bit disagrees with queue state");

    property p_unused_zero;
        @(posedge clk) disable iff (!nrst)
        rd_queue |=> (rdata[6:5] == 2'b00);
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused queue bits read nonzero");

    property p_chan_number;
        @(posedge clk) disable iff (!nrst)
        (rd_queue && !q_empty) |=> (rdata[`QUEUE_CHAN_MSB:0] == $past(q_head));
    endproperty
    a_chan_number: assert property (p_chan_number)
        else $error("queue read returned the wrong channel");

    property p_event_queued;
        @(posedge clk) disable iff (!nrst)
        (evt_valid && !q_full && !q_pop) |=> !q_empty ##0 status_q[`STAT_QUEUED_BIT];
    endproperty
    a_event_queued: assert property (p_event_queued)
        else $error("pending event was not queued");

    property p_reset_zero;
        @(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> (rdata == 8'h00 && test_q == 1'b0);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("registers not zero after reset");

    property p_last_read_clears;
        @(posedge clk) disable iff (!nrst)
        (q_pop && !q_push && !evt_valid && $past(q_empty) == 1'b0 && u_queue.count_q == 1)
            |=> (irq_pending == 1'b0);
    endproperty
    a_last_read_clears: assert property (p_last_read_clears)
        else $error("pending stayed high after the last entry was read");

    property p_test_bit_write;
        @(posedge clk) disable iff (!nrst)
        wr_selftest |=> (test_mode == $past(wdata[0]));
    endproperty
    a_test_bit_write: assert property (p_test_bit_write)
        else $error("test bit did not take the written value");

    property p_irq_level;
        @(posedge clk) disable iff (!nrst)
        (status_q[`STAT_QUEUED_BIT] && mask_q[`STAT_QUEUED_BIT]) |-> irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("irq low with an unmasked status bit set");

    // queue word and pending output
    property p_word_pend;
        @(posedge clk) disable iff (!nrst)
        queue_word[`QUEUE_PEND_BIT] == irq_pending;
    endproperty
    a_word_pend: assert property (p_word_pend)
        else $error("pending bit and output differ");

    property p_word_unused;
        @(posedge clk) disable iff (!nrst)
        queue_word[6:5] == 2'b00;
    endproperty
    a_word_unused: assert property (p_word_unused)
        else $error("unused queue bits set");

    property p_pending_rises;
        @(posedge clk) disable iff (!nrst)
        q_push |=> irq_pending;
    endproperty
    a_pending_rises: assert property (p_pending_rises)
        else $error("pending low after a push");

    // first edge after release: nothing may be set yet
    property p_reset_quiet;
        @(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> (!irq && !irq_pending && status_q == '0);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("flags set at reset release");

    // register read-back
    // idle read data are zero so a late sample never sees a stale word
    property p_rdata_idle;
        @(posedge clk) disable iff (!nrst)
        !rd |=> (rdata == 8'h00);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data without a read");

    property p_selftest_read;
        @(posedge clk) disable iff (!nrst)
        (rd && sel == tone_irq_pkg::SEL_SELFTEST) |=> (rdata == {7'h00, $past(test_q)});
    endproperty
    a_selftest_read: assert property (p_selftest_read)
        else $error("self-test read wrong");

    property p_status_read;
        @(posedge clk) disable iff (!nrst)
        (rd && sel == tone_irq_pkg::SEL_STATUS) |=> (rdata == {6'h00, $past(status_q)});
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read wrong");

    property p_mask_read;
        @(posedge clk) disable iff (!nrst)
        (rd && sel == tone_irq_pkg::SEL_MASK) |=> (rdata == {6'h00, $past(mask_q)});
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("mask read wrong");

    property p_unmapped_read;
        @(posedge clk) disable iff (!nrst)
        (rd && sel == tone_irq_pkg::SEL_NONE) |=> (rdata == 8'h00);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read nonzero");

    // writes to the read-only queue must not disturb it
    property p_queue_wr_ignored;
        @(posedge clk) disable iff (!nrst)
        (wr && !rd && sel == tone_irq_pkg::SEL_QUEUE && !q_push)
            |=> (u_queue.count_q == $past(u_queue.count_q));
    endproperty
    a_queue_wr_ignored: assert property (p_queue_wr_ignored)
        else $error("queue write changed the queue");

    // status, mask and self-test bit
    // a held-back event must stay pending, or it would be lost
    property p_full_holds_back;
        @(posedge clk) disable iff (!nrst)
        (ovfl_evt && !q_pop) |=> (evt_valid && status_q[`STAT_OVFL_BIT]);
    endproperty
    a_full_holds_back: assert property (p_full_holds_back)
        else $error("held-back event lost");

    property p_w1c;
        @(posedge clk) disable iff (!nrst)
        (wr_status && set_bits == '0) |=> ((status_q & $past(wdata[`STAT_W-1:0])) == '0);
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("status bit not cleared");

    property p_set_wins;
        @(posedge clk) disable iff (!nrst)
        (wr_status && q_push) |=> status_q[`STAT_QUEUED_BIT];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear beat a set");

    property p_mask_write;
        @(posedge clk) disable iff (!nrst)
        wr_mask |=> (mask_q == $past(wdata[`STAT_W-1:0]));
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("mask not written");

    property p_test_hold;
        @(posedge clk) disable iff (!nrst)
        !wr_selftest |=> (test_q == $past(test_q));
    endproperty
    a_test_hold: assert property (p_test_hold)
        else $error("test bit changed without a write");

    // queue order
    // a push behind the head must never replace the oldest entry
    property p_head_kept;
        @(posedge clk) disable iff (!nrst)
        (!q_pop && !q_empty) |=> (q_head == $past(q_head));
    endproperty
    a_head_kept: assert property (p_head_kept)
        else $error("head moved without a read");

    c_tone_event: cover property (@(posedge clk) disable iff (!nrst)
        (tone_disable != u_detect.tone_q) ##[1:4] q_push);
    c_test_event: cover property (@(posedge clk) disable iff (!nrst)
        test_q && (group_tone_ctrl_a != u_detect.ctrl_a_q) ##[1:4] q_push);
    c_drain: cover property (@(posedge clk) disable iff (!nrst)
        q_pop ##1 q_empty);
    c_full: cover property (@(posedge clk) disable iff (!nrst) ovfl_evt);
    c_status_clear: cover property (@(posedge clk) disable iff (!nrst)
        wr_status ##1 !irq);
endmodule

/* File: core/tone_irq_pkg.sv */
/*
 * Types shared by the tone event interrupt block.
 * Assumes the constants header is included by each design file.
 */
package tone_irq_pkg;
    typedef logic [4:0] chan_t;
    typedef logic [7:0] byte_t;
    typedef enum logic [2:0] {
        SEL_NONE     = 3'b000,
        SEL_QUEUE    = 3'b001,
        SEL_SELFTEST = 3'b010,
        SEL_STATUS   = 3'b011,
        SEL_MASK     = 3'b100
    } reg_sel_t;
endpackage

/* File: core/tone_irq_regs.svh */
/*
 * Register map, field positions, reset values and sizes of the
 * tone event interrupt block.
 * Assumes a 12-bit byte address on the plain register port.
 */
// Operation
// - bit 7 of the queue register at 410h reads high while an interrupt is pending, else low.
// - bits 6 and 5 of the queue register always read zero.
// - bits 4 to 0 of the queue register hold the binary number of the changed channel.
// - an interrupt is raised when a tone disable is detected on a channel and when released.
// - with the test bit high, any change written to a group tone control bit queues its channel.
// - with the test bit low, only real tone detector changes raise interrupts.
`ifndef TONE_IRQ_REGS_SVH
`define TONE_IRQ_REGS_SVH

`define ADDR_W            12
`define ADDR_QUEUE        12'h410
`define ADDR_SELFTEST     12'h411
`define ADDR_IRQ_STATUS   12'h412
`define ADDR_IRQ_MASK     12'h413

`define QUEUE_PEND_BIT    7
`define QUEUE_CHAN_MSB    4
`define SELFTEST_EN_BIT   0

`define STAT_QUEUED_BIT   0
`define STAT_OVFL_BIT     1
`define STAT_W            2

`define QUEUE_RESET       8'h00
`define SELFTEST_RESET    8'h00
`define IRQ_MASK_RESET    2'h1

`define NUM_CHANNELS      32
`define NUM_GROUPS        16
`define QUEUE_DEPTH       32

`endif

/* File: verif/tb_tone_event_interrupt_fifo.sv */
/*
 * Self-checking bench of the tone event interrupt block.
 * Assumes the host model drives the register port; read results are
 * queued at request time and matched by a monitor one cycle later.
 */
`timescale 1ns/1ps
`include "tone_irq_regs.svh"
module tb_tone_event_interrupt_fifo;
    logic                   clk;
    logic                   nrst;
    logic [`ADDR_W-1:0]     addr;
    logic [7:0]             wdata;
    logic                   wr;
    logic                   rd;
    logic [7:0]             rdata;
    logic [31:0]            tone;
    logic [15:0]            ga;
    logic [15:0]            gb;
    logic                   test_mode;
    logic                   irq_pending;
    logic                   irq;
    logic                   rd_prev;
    logic [31:0]            seed;
    tone_irq_pkg::byte_t    exp_q[$];
    int                     mismatches;
    int                     n_tests;

    tone_host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

    tone_event_interrupt_fifo DUT (
        .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .tone_disable(tone), .group_tone_ctrl_a(ga),
        .group_tone_ctrl_b(gb), .test_mode(test_mode), .irq_pending(irq_pending),
        .irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk8(input tone_irq_pkg::byte_t got, input tone_irq_pkg::byte_t exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clk) rd_prev <= rd;
    always @(negedge clk) begin
        if (rd_prev === 1'b1) begin
            if (exp_q.size() == 0)
                chk8(rdata, 8'hee);
            else
                chk8(rdata, exp_q.pop_front());
        end
    end

    task automatic rd_chk(input logic [`ADDR_W-1:0] a, input tone_irq_pkg::byte_t e);
        exp_q.push_back(e);
        host.bus_rd(a);
    endtask

    task automatic wait_pend();
        int i;
        i = 0;
        while (irq_pending !== 1'b1 && i < 10) begin
            @(negedge clk);
            i++;
        end
        chk1(irq_pending, 1'b1);
    endtask

    // k: 0 tone detector, 1 group side a, 2 group side b
    task automatic evt(input int k, input int i, input tone_irq_pkg::chan_t c);
        @(posedge clk);
        case (k)
            0: tone[i] <= ~tone[i];
            1: ga[i] <= ~ga[i];
            default: gb[i] <= ~gb[i];
        endcase
        wait_pend();
        rd_chk(`ADDR_QUEUE, {1'b1, 2'b00, c});
        @(negedge clk);
        chk1(irq_pending, 1'b0);
    endtask

    task automatic test_done();
        $display("counts: compares=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("BAD t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
        test_done();
    end

    initial begin
        int j;
        int g;
        nrst = 1'b0;
        tone = 32'h0000_0000;
        ga = 16'h0000;
        gb = 16'h0000;
        mismatches = 0;
        n_tests = 0;
        seed = 32'h0001_7fb5;
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk1(irq_pending, 1'b0);
        chk1(test_mode, 1'b0);
        @(posedge clk);
        nrst <= 1'b1;
        rd_chk(`ADDR_QUEUE, 8'h00);
        rd_chk(`ADDR_SELFTEST, 8'h00);
        rd_chk(`ADDR_IRQ_STATUS, 8'h00);
        rd_chk(`ADDR_IRQ_MASK, 8'h01);
        rd_chk(12'h5a5, 8'h00);
        $display("test reset values done");

        // detect and release on random channels
        for (j = 0; j < 4; j++) begin
            seed = lfsr(seed);
            evt(0, seed[4:0], seed[4:0]);
            evt(0, seed[4:0], seed[4:0]);
        end
        $display("test tone events done");

        // two changes at once drain lowest first, reads one idle cycle apart
        @(posedge clk);
        tone[3] <= ~tone[3];
        tone[9] <= ~tone[9];
        wait_pend();
        repeat (3) @(posedge clk);
        rd_chk(`ADDR_QUEUE, 8'h83);
        rd_chk(`ADDR_QUEUE, 8'h89);
        rd_chk(`ADDR_QUEUE, 8'h00);
        $display("test queue order done");

        // queue is read-only; test bit set with reserved bits zero
        host.bus_wr(`ADDR_QUEUE, 8'hff);
        rd_chk(`ADDR_QUEUE, 8'h00);
        host.bus_wr(`ADDR_SELFTEST, 8'h01);
        rd_chk(`ADDR_SELFTEST, 8'h01);
        chk1(test_mode, 1'b1);
        for (j = 0; j < 2; j++) begin
            seed = lfsr(seed);
            g = seed[3:0];
            evt(1, g, tone_irq_pkg::chan_t'(2 * g));
            evt(2, g, tone_irq_pkg::chan_t'(2 * g + 1));
        end
        host.bus_wr(`ADDR_SELFTEST, 8'h00);
        @(posedge clk);
        ga[g] <= ~ga[g];
        gb[5] <= ~gb[5];
        repeat (6) @(negedge clk);
        chk1(irq_pending, 1'b0);
        rd_chk(`ADDR_QUEUE, 8'h00);
        $display("test self-test mode done");

        // sticky status, mask and write-one-clear
        host.bus_wr(`ADDR_IRQ_STATUS, 8'h03);
        @(negedge clk);
        chk1(irq, 1'b0);
        evt(0, 31, 5'h1f);
        chk1(irq, 1'b1);
        rd_chk(`ADDR_IRQ_STATUS, 8'h01);
        host.bus_wr(`ADDR_IRQ_MASK, 8'h00);
        @(negedge clk);
        chk1(irq, 1'b0);
        host.bus_wr(`ADDR_IRQ_MASK, 8'h01);
        @(negedge clk);
        chk1(irq, 1'b1);
        host.bus_wr(`ADDR_IRQ_STATUS, 8'h01);
        @(negedge clk);
        chk1(irq, 1'b0);
        $display("test interrupt status done");

        // fill the queue, hold one event back, then drain it all
        @(posedge clk);
        tone <= ~tone;
        repeat (40) @(posedge clk);
        tone[0] <= ~tone[0];
        repeat (4) @(posedge clk);
        rd_chk(`ADDR_IRQ_STATUS, 8'h03);
        for (j = 0; j < 32; j++)
            rd_chk(`ADDR_QUEUE, {3'b100, tone_irq_pkg::chan_t'(j)});
        rd_chk(`ADDR_QUEUE, 8'h80);
        rd_chk(`ADDR_QUEUE, 8'h00);
        $display("test queue overflow done");

        repeat (3) @(posedge clk);
        test_done();
    end
endmodule

/* File: verif/tone_host_model.sv */
/*
 * Host processor model on the plain register port: one-cycle write
 * and read strobes, launched just after a rising clock edge.
 * Assumes the slave never stalls and read data follow one cycle later.
 */
`timescale 1ns/1ps
`include "tone_irq_regs.svh"
module tone_host_model (
    input  wire logic                 clk,
    output logic [`ADDR_W-1:0]        addr,
    output logic [7:0]                wdata,
    output logic                      wr,
    output logic                      rd
);
    initial begin
        addr  = '0;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // normal use keeps the reserved self-test bits at zero
    task automatic bus_wr(input logic [`ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic bus_rd(input logic [`ADDR_W-1:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
    endtask
endmodule
